// *** rtl/lp_timer_pkg.sv ***
// package: register map, field positions and reset values of the timer
// assumes: classic wishbone slave with 32-bit data, byte registers in bits 7:0
package lp_timer_pkg;
    localparam logic [3:0] ADDR_TIMER_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_COUNT_LOW = 4'h4;
    localparam logic [3:0] ADDR_COUNT_HIGH = 4'h8;
    localparam logic [3:0] ADDR_OSC_CONTROL = 4'hc;
    localparam logic [3:0] ADDR_PERIPH_FLAG = 4'h0;
    localparam logic [3:0] ADDR_PERIPH_ENABLE = 4'h4;
    localparam logic [3:0] ADDR_COMPARE_A = 4'h8;
    localparam logic [3:0] ADDR_COMPARE_B = 4'hc;
    localparam logic ADDR_BANK_TIMER = 1'b0;
    localparam logic ADDR_BANK_EVENT = 1'b1;
    // timer control register bit positions
    localparam int BIT_RUN = 0;
    localparam int BIT_CLK_SEL = 1;
    localparam int BIT_SYNC_DIS = 2;
    localparam int BIT_OSC_EN = 3;
    localparam int BIT_PS_LO = 4;
    localparam int BIT_PS_HI = 5;
    localparam int BIT_CLK_ACTIVE = 6;
    localparam int BIT_WIDE = 7;
    // oscillator control register bit positions
    localparam int BIT_SCS_LO = 0;
    localparam int BIT_SCS_HI = 1;
    localparam int BIT_LOW_POWER = 2;
    localparam int BIT_FAIL_SAFE = 3;
    localparam int BIT_IDLE_EN = 7;
    localparam int BIT_OVF = 0;
    localparam logic [1:0] SCS_SECONDARY = 2'h1;
    localparam logic [3:0] MODE_SPECIAL_TRIGGER = 4'hb;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [2:0] PS_ZERO = 3'h0;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
    // prescale terminal counts for 1:1, 1:2, 1:4, 1:8
    localparam logic [2:0] PS_LAST_1 = 3'h0;
    localparam logic [2:0] PS_LAST_2 = 3'h1;
    localparam logic [2:0] PS_LAST_4 = 3'h3;
    localparam logic [2:0] PS_LAST_8 = 3'h7;
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

    typedef enum logic [1:0] {
        PM_RUN = 2'b00,
        PM_SEC_RUN = 2'b01,
        PM_SEC_IDLE = 2'b10,
        PM_SLEEP = 2'b11
    } pm_state_t;

    typedef struct packed {
        logic [3:0] mode;
        logic [15:0] value;
    } compare_cfg_t;
endpackage

// *** rtl/lp_osc_timer_counter.sv ***
// lp_osc_timer_counter: 16-bit timer/counter with secondary oscillator
// control, power mode tracking and compare special event trigger reset.
// assumes: wishbone classic master on clk_sys, oscillator pins asynchronous
//
// Notes on behaviour
// - oscillator runs only while enable bit set
// - enabled oscillator keeps running in all modes
// - select 01 enters secondary run mode
// - sleep from secondary run with idle bit clear enters secondary idle
// - status flag shows secondary clock in use
// - fail-safe failover clears status flag
// - config bit picks oscillator power level
// - count wraps from FFFF to 0000
// - wrap latches overflow flag until cleared
// - interrupt request only when enable set
// - compare mode 1011 trigger clears count
// - compare value becomes the timer period
// - enhanced trigger starts enabled conversion
// - software write beats coincident trigger
// - trigger reset never sets overflow flag
// - clock select picks instruction or external
// - prescale field divides by 1,2,4,8
// - sync-disable bit is stored only; external input is synchronised either way
// - wide mode buffers high byte through low
`timescale 1ns/1ps
`default_nettype none
module lp_osc_timer_counter (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sec_osc_in_pin,
    input wire logic sleep_request,
    input wire logic osc_fail,
    input wire logic adc_enable,
    output logic sec_osc_out_pin,
    output logic sec_osc_run,
    output logic sec_osc_low_power_cfg,
    output logic sec_clock_active_flag,
    output logic [1:0] power_mode,
    output logic overflow_irq,
    output logic adc_start
);
    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [1:0] osc_pin_sync_r, osc_pin_sync_nxt;
    logic [1:0] sleep_sync_r, sleep_sync_nxt;
    logic [1:0] fail_sync_r, fail_sync_nxt;
    logic [1:0] adc_sync_r, adc_sync_nxt;
    logic ext_level_r, ext_level_nxt;

    always_comb begin
        osc_pin_sync_nxt = {osc_pin_sync_r[0], sec_osc_in_pin};
        sleep_sync_nxt = {sleep_sync_r[0], sleep_request};
        fail_sync_nxt = {fail_sync_r[0], osc_fail};
        adc_sync_nxt = {adc_sync_r[0], adc_enable};
        ext_level_nxt = osc_pin_sync_r[1];
    end

    always_ff @(posedge clk_sys) begin
        osc_pin_sync_r <= osc_pin_sync_nxt;
        sleep_sync_r <= sleep_sync_nxt;
        fail_sync_r <= fail_sync_nxt;
        adc_sync_r <= adc_sync_nxt;
        ext_level_r <= ext_level_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers and bus slave
    logic [7:0] tctl_r, tctl_nxt;
    logic [7:0] octl_r, octl_nxt;
    logic [7:0] high_buf_r, high_buf_nxt;
    logic flag_r, flag_nxt;
    logic irq_en_r, irq_en_nxt;
    lp_timer_pkg::compare_cfg_t cmp_a_r, cmp_a_nxt, cmp_b_r, cmp_b_nxt;
    logic [15:0] count_r, count_nxt;
    logic [2:0] ps_r, ps_nxt;
    logic [1:0] idiv_r, idiv_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic ack_r, ack_nxt;
    lp_timer_pkg::pm_state_t pm_r, pm_nxt;
    logic active_r, active_nxt;
    logic adc_start_r, adc_start_nxt;
    logic irq_r, irq_nxt;
    logic out_pin_r, out_pin_nxt;

    logic req, wr, rd, lane0, bank;
    logic [3:0] off;
    logic wr_low, wr_high, rd_low;
    logic tick, wrap, trig_a, trig_b;
    logic [2:0] ps_last;

    always_comb begin
        req = wb_cyc_i && wb_stb_i && !ack_r;
        wr = req && wb_we_i;
        rd = req && !wb_we_i;
        lane0 = wb_sel_i[0];
        bank = wb_adr_i[4];
        off = wb_adr_i[3:0];
        wr_low = wr && lane0 && bank == lp_timer_pkg::ADDR_BANK_TIMER
            && off == lp_timer_pkg::ADDR_COUNT_LOW;
        wr_high = wr && lane0 && bank == lp_timer_pkg::ADDR_BANK_TIMER
            && off == lp_timer_pkg::ADDR_COUNT_HIGH;
        rd_low = rd && bank == lp_timer_pkg::ADDR_BANK_TIMER
            && off == lp_timer_pkg::ADDR_COUNT_LOW;
    end

    always_comb begin
        tctl_nxt = tctl_r;
        octl_nxt = octl_r;
        irq_en_nxt = irq_en_r;
        cmp_a_nxt = cmp_a_r;
        cmp_b_nxt = cmp_b_r;
        high_buf_nxt = high_buf_r;
        ack_nxt = req;
        dat_nxt = lp_timer_pkg::READ_ZERO;
        if (wr && lane0) begin
            if (bank == lp_timer_pkg::ADDR_BANK_TIMER) begin
                if (off == lp_timer_pkg::ADDR_TIMER_CONTROL) begin
                    tctl_nxt = wb_dat_i[7:0];
                end else if (off == lp_timer_pkg::ADDR_COUNT_HIGH) begin
                    high_buf_nxt = wb_dat_i[7:0];
                end else if (off == lp_timer_pkg::ADDR_OSC_CONTROL) begin
                    octl_nxt = wb_dat_i[7:0];
                end
            end else begin
                if (off == lp_timer_pkg::ADDR_PERIPH_ENABLE) begin
                    irq_en_nxt = wb_dat_i[lp_timer_pkg::BIT_OVF];
                end else if (off == lp_timer_pkg::ADDR_COMPARE_A) begin
                    cmp_a_nxt = wb_dat_i[19:0];
                end else if (off == lp_timer_pkg::ADDR_COMPARE_B) begin
                    cmp_b_nxt = wb_dat_i[19:0];
                end
            end
        end
        if (wr && wb_sel_i[1] && bank == lp_timer_pkg::ADDR_BANK_EVENT) begin
            if (off == lp_timer_pkg::ADDR_COMPARE_A) begin
                cmp_a_nxt.value[15:8] = wb_dat_i[15:8];
            end else if (off == lp_timer_pkg::ADDR_COMPARE_B) begin
                cmp_b_nxt.value[15:8] = wb_dat_i[15:8];
            end
        end
        if (rd_low && tctl_r[lp_timer_pkg::BIT_WIDE]) begin
            high_buf_nxt = count_r[15:8];
        end
        if (rd) begin
            if (bank == lp_timer_pkg::ADDR_BANK_TIMER) begin
                if (off == lp_timer_pkg::ADDR_TIMER_CONTROL) begin
                    dat_nxt[7:0] = {tctl_r[7], active_r, tctl_r[5:0]};
                end else if (off == lp_timer_pkg::ADDR_COUNT_LOW) begin
                    dat_nxt[7:0] = count_r[7:0];
                end else if (off == lp_timer_pkg::ADDR_COUNT_HIGH) begin
                    dat_nxt[7:0] = tctl_r[lp_timer_pkg::BIT_WIDE] ?
                        high_buf_r : count_r[15:8];
                end else begin
                    dat_nxt[7:0] = octl_r;
                end
            end else begin
                if (off == lp_timer_pkg::ADDR_PERIPH_FLAG) begin
                    dat_nxt[lp_timer_pkg::BIT_OVF] = flag_r;
                end else if (off == lp_timer_pkg::ADDR_PERIPH_ENABLE) begin
                    dat_nxt[lp_timer_pkg::BIT_OVF] = irq_en_r;
                end else if (off == lp_timer_pkg::ADDR_COMPARE_A) begin
                    dat_nxt[19:0] = cmp_a_r;
                end else begin
                    dat_nxt[19:0] = cmp_b_r;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock source, prescaler and count
    always_comb begin
        case (tctl_r[lp_timer_pkg::BIT_PS_HI:lp_timer_pkg::BIT_PS_LO])
            2'b00: ps_last = lp_timer_pkg::PS_LAST_1;
            2'b01: ps_last = lp_timer_pkg::PS_LAST_2;
            2'b10: ps_last = lp_timer_pkg::PS_LAST_4;
            default: ps_last = lp_timer_pkg::PS_LAST_8;
        endcase
        // external edges qualify through the synchroniser either way
        if (tctl_r[lp_timer_pkg::BIT_CLK_SEL]) begin
            tick = osc_pin_sync_r[1] && !ext_level_r;
        end else begin
            tick = idiv_r == lp_timer_pkg::INSTR_DIV_LAST;
        end
        trig_a = cmp_a_r.mode == lp_timer_pkg::MODE_SPECIAL_TRIGGER
            && count_r == cmp_a_r.value;
        trig_b = cmp_b_r.mode == lp_timer_pkg::MODE_SPECIAL_TRIGGER
            && count_r == cmp_b_r.value;
        idiv_nxt = idiv_r + 2'h1;
        ps_nxt = ps_r;
        count_nxt = count_r;
        wrap = 1'b0;
        if (tctl_r[lp_timer_pkg::BIT_RUN] && tick) begin
            if (ps_r >= ps_last) begin
                ps_nxt = lp_timer_pkg::PS_ZERO;
                count_nxt = count_r + 16'h0001;
                wrap = count_r == lp_timer_pkg::COUNT_MAX;
            end else begin
                ps_nxt = ps_r + 3'h1;
            end
        end
        if (wr_low) begin
            count_nxt[7:0] = wb_dat_i[7:0];
            if (tctl_r[lp_timer_pkg::BIT_WIDE]) begin
                count_nxt[15:8] = high_buf_r;
            end
            ps_nxt = lp_timer_pkg::PS_ZERO;
            wrap = 1'b0;
        end else if (wr_high && !tctl_r[lp_timer_pkg::BIT_WIDE]) begin
            count_nxt[15:8] = wb_dat_i[7:0];
            wrap = 1'b0;
        end else if (tctl_r[lp_timer_pkg::BIT_RUN] && (trig_a || trig_b)) begin
            count_nxt = lp_timer_pkg::COUNT_ZERO;
            wrap = 1'b0;
        end
        // set wins over a software clear
        flag_nxt = flag_r;
        if (wr && lane0 && bank == lp_timer_pkg::ADDR_BANK_EVENT
            && off == lp_timer_pkg::ADDR_PERIPH_FLAG) begin
            flag_nxt = wb_dat_i[lp_timer_pkg::BIT_OVF];
        end
        if (wrap) begin
            flag_nxt = 1'b1;
        end
        irq_nxt = flag_r && irq_en_r;
        adc_start_nxt = tctl_r[lp_timer_pkg::BIT_RUN] && trig_a
            && adc_sync_r[1];
    end

    ////////////////////////////////////////////////////////////////////////
    // power-managed mode tracking
    always_comb begin
        pm_nxt = pm_r;
        case (pm_r)
            lp_timer_pkg::PM_RUN: begin
                if (octl_r[lp_timer_pkg::BIT_SCS_HI:lp_timer_pkg::BIT_SCS_LO]
                    == lp_timer_pkg::SCS_SECONDARY) begin
                    pm_nxt = lp_timer_pkg::PM_SEC_RUN;
                end else if (sleep_sync_r[1]) begin
                    pm_nxt = lp_timer_pkg::PM_SLEEP;
                end
            end
            lp_timer_pkg::PM_SEC_RUN: begin
                if (octl_r[lp_timer_pkg::BIT_SCS_HI:lp_timer_pkg::BIT_SCS_LO]
                    != lp_timer_pkg::SCS_SECONDARY) begin
                    pm_nxt = lp_timer_pkg::PM_RUN;
                end else if (sleep_sync_r[1]) begin
                    pm_nxt = octl_r[lp_timer_pkg::BIT_IDLE_EN] ?
                        lp_timer_pkg::PM_SLEEP : lp_timer_pkg::PM_SEC_IDLE;
                end
            end
            default: begin
                if (!sleep_sync_r[1]) begin
                    pm_nxt = lp_timer_pkg::PM_RUN;
                end
            end
        endcase
        // failover only counts when the monitor is on
        active_nxt = (pm_r == lp_timer_pkg::PM_SEC_RUN
            || pm_r == lp_timer_pkg::PM_SEC_IDLE)
            && tctl_r[lp_timer_pkg::BIT_OSC_EN]
            && !(octl_r[lp_timer_pkg::BIT_FAIL_SAFE] && fail_sync_r[1]);
        // amplifier drive registered so the pin comes from a flop
        out_pin_nxt = tctl_nxt[lp_timer_pkg::BIT_OSC_EN]
            && !ext_level_nxt;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tctl_r <= lp_timer_pkg::RESET_BYTE;
            octl_r <= lp_timer_pkg::RESET_BYTE;
            high_buf_r <= lp_timer_pkg::RESET_BYTE;
            flag_r <= 1'b0;
            irq_en_r <= 1'b0;
            cmp_a_r <= '0;
            cmp_b_r <= '0;
            count_r <= lp_timer_pkg::COUNT_ZERO;
            ps_r <= lp_timer_pkg::PS_ZERO;
            idiv_r <= 2'h0;
            dat_r <= lp_timer_pkg::READ_ZERO;
            ack_r <= 1'b0;
            pm_r <= lp_timer_pkg::PM_RUN;
            active_r <= 1'b0;
            adc_start_r <= 1'b0;
            irq_r <= 1'b0;
            out_pin_r <= 1'b0;
        end else begin
            tctl_r <= tctl_nxt;
            octl_r <= octl_nxt;
            high_buf_r <= high_buf_nxt;
            flag_r <= flag_nxt;
            irq_en_r <= irq_en_nxt;
            cmp_a_r <= cmp_a_nxt;
            cmp_b_r <= cmp_b_nxt;
            count_r <= count_nxt;
            ps_r <= ps_nxt;
            idiv_r <= idiv_nxt;
            dat_r <= dat_nxt;
            ack_r <= ack_nxt;
            pm_r <= pm_nxt;
            active_r <= active_nxt;
            adc_start_r <= adc_start_nxt;
            irq_r <= irq_nxt;
            out_pin_r <= out_pin_nxt;
        end
    end

    // oscillator enable is independent of power mode
    always_comb begin
        wb_dat_o = dat_r;
        wb_ack_o = ack_r;
        sec_osc_run = tctl_r[lp_timer_pkg::BIT_OSC_EN];
        sec_osc_out_pin = out_pin_r;
        sec_osc_low_power_cfg = octl_r[lp_timer_pkg::BIT_LOW_POWER];
        sec_clock_active_flag = active_r;
        power_mode = pm_r;
        overflow_irq = irq_r;
        adc_start = adc_start_r;
    end
endmodule // lp_osc_timer_counter
`default_nettype wire

// *** verif/lp_timer_monitor.sv ***
// checker: oscillator, power mode, status flag and trigger gating
// assumes: bound to the timer top, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module lp_timer_monitor (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic sleep_request,
    input wire logic osc_fail,
    input wire logic adc_enable,
    input wire logic sec_osc_run,
    input wire logic sec_osc_low_power_cfg,
    input wire logic sec_clock_active_flag,
    input wire logic [1:0] power_mode,
    input wire logic adc_start
);
default clocking cb @(posedge clk_sys); endclocking
default disable iff (reset);
////////////////////////////////////////
// shadow of idle-enable and fail-safe bits, taken at write acks
logic [1:0] osc_bits_r;
logic [1:0] osc_bits_nxt;
wire logic wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0];
always_comb begin
    osc_bits_nxt = osc_bits_r;
    if (wr_ack && wb_adr_i == 5'h0c) begin
        osc_bits_nxt = {wb_dat_i[7], wb_dat_i[3]};
    end
end
always_ff @(posedge clk_sys) begin
    osc_bits_r <= reset ? 2'b00 : osc_bits_nxt;
end
////////////////////////////////////////
osc_en_write_a: assert property (wr_ack && wb_adr_i == 5'h00
    |=> sec_osc_run == $past(wb_dat_i[3])) else $error("osc enable lost");
osc_hold_a: assert property (sec_osc_run && !(wb_stb_i && wb_we_i)
    |=> sec_osc_run) else $error("oscillator stopped by itself");
lp_default_a: assert property ($fell(reset)
    |-> !sec_osc_low_power_cfg) else $error("power level default wrong");
lp_write_a: assert property (wr_ack && wb_adr_i == 5'h0c
    |=> sec_osc_low_power_cfg == $past(wb_dat_i[2]))
    else $error("power level not written");
sec_run_entry_a: assert property (wr_ack && wb_adr_i == 5'h0c
    && wb_dat_i[1:0] == 2'b01 && !sleep_request
    |-> ##[0:4] power_mode == lp_timer_pkg::PM_SEC_RUN)
    else $error("secondary run not entered");
idle_entry_a: assert property ($rose(sleep_request) && !osc_bits_r[1]
    && power_mode == lp_timer_pkg::PM_SEC_RUN ##1 sleep_request [*6]
    |-> power_mode == lp_timer_pkg::PM_SEC_IDLE)
    else $error("secondary idle not entered");
flag_source_a: assert property (sec_clock_active_flag
    |-> (sec_osc_run || $past(sec_osc_run))
    && (^power_mode || ^$past(power_mode))) else $error("status flag wrong");
failover_clear_a: assert property ((osc_bits_r[0] && osc_fail) [*5]
    |-> !sec_clock_active_flag) else $error("flag kept after failure");
adc_gate_a: assert property (!adc_enable [*6]
    |-> !adc_start) else $error("conversion start while disabled");
cover property (power_mode == lp_timer_pkg::PM_SEC_IDLE);
cover property (adc_start);
cover property ($fell(sec_clock_active_flag));
endmodule // lp_timer_monitor
bind lp_osc_timer_counter lp_timer_monitor u_mon (.clk_sys, .reset,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
    .sleep_request, .osc_fail, .adc_enable, .sec_osc_run,
    .sec_osc_low_power_cfg, .sec_clock_active_flag, .power_mode,
    .adc_start);
`default_nettype wire

// *** verif/lp_xtal_model.sv ***
// partner: watch crystal on the oscillator pins as a square wave
// assumes: amplifier enable from the timer, phase unrelated to clk_sys
`timescale 1ns/1ps
`default_nettype none
module lp_xtal_model #(
    parameter int HALF_NS = 170,
    parameter int START_NS = 2003
) (
    input wire logic amp_enable,
    output logic xtal_in
);
// no swing until the amplifier is on and start-up has elapsed
// odd start offset keeps pin changes off the clock edges
initial begin
    xtal_in = 1'b0;
    forever begin
        wait (amp_enable === 1'b1);
        #(START_NS);
        while (amp_enable === 1'b1) begin
            #(HALF_NS) xtal_in = ~xtal_in;
        end
        xtal_in = 1'b0;
    end
end
endmodule // lp_xtal_model
`default_nettype wire

// *** verif/lp_osc_timer_counter_tb_top.sv ***
// testbench: bus-driven checks of count, oscillator and trigger
// assumes: crystal model on the input pin, checker bound to the design
`timescale 1ns/1ps
`default_nettype none
module lp_osc_timer_counter_tb_top;
logic clk_sys, reset, cyc, stb, we, sleep, fail, adc_en;
logic ack, xin, xout, osc_run, lp_cfg, active, irq, adc_st;
logic [4:0] adr;
logic [3:0] sel;
logic [31:0] wdat, rdat;
logic [1:0] pmode;
logic [15:0] v;
logic [15:0] exp_q[$];
int num_errors, cmp_count, seed, adc_cnt, i;
lp_osc_timer_counter u_dut (.clk_sys, .reset, .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sec_osc_in_pin(xin), .sleep_request(sleep), .osc_fail(fail),
    .adc_enable(adc_en), .sec_osc_out_pin(xout), .sec_osc_run(osc_run),
    .sec_osc_low_power_cfg(lp_cfg), .sec_clock_active_flag(active),
    .power_mode(pmode), .overflow_irq(irq), .adc_start(adc_st));
lp_xtal_model u_xtal (.amp_enable(osc_run), .xtal_in(xin));
initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
end
////////////////////////////////////////
task automatic close_out;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
        $display("Test passed");
    end else begin
        $display("Test failed");
    end
    $finish;
endtask
task automatic chk_pin(input string nm, input logic [1:0] e,
    input logic [1:0] s);
    cmp_count++;
    if (s !== e) begin
        num_errors++;
        $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
endtask
// low byte compared within a tolerance carried in the note
task automatic chk_rd(input logic [15:0] et, input logic [31:0] s);
    int d;
    d = int'(s[7:0]) - int'(et[7:0]);
    cmp_count++;
    if ($isunknown(s) || s[31:8] !== 24'h00_0000 || d > int'(et[15:8])
        || -d > int'(et[15:8])) begin
        num_errors++;
        $display("MISMATCH read %h expected %h seen %h", adr, et[7:0], s);
    end
endtask
task automatic bus(input logic [4:0] a, input logic w, input logic [19:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= 32'(d);
    // only the watchdog ends a wait for the answer
    do begin
        @(posedge clk_sys);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
endtask
task automatic wr(input logic [4:0] a, input logic [19:0] d);
    bus(a, 1'b1, d);
endtask
task automatic rd(input logic [4:0] a, input logic [7:0] e, input int t);
    exp_q.push_back({8'(t), e});
    bus(a, 1'b0, 20'h0_0000);
endtask
task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
endtask
////////////////////////////////////////
always @(posedge clk_sys) begin
    if (adc_st === 1'b1) adc_cnt++;
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
        chk_rd(exp_q.pop_front(), rdat);
    end
end
initial begin
    #400_000;
    num_errors++;
    close_out();
end
initial begin
    {cyc, stb, we, sleep, fail, adc_en} = 6'h00;
    adr = 5'h00;
    sel = 4'hf;
    wdat = 32'h0000_0000;
    reset = 1'b1;
    seed = 77;
    tick(12);
    reset <= 1'b0;
    rd(5'h00, 8'h00, 0);
    rd(5'h0c, 8'h00, 0);
    chk_pin("out_pin", 2'd0, {1'b0, xout});
    wr(5'h00, 20'h0_0008);
    tick(2);
    chk_pin("osc_run", 2'd1, {1'b0, osc_run});
    wr(5'h0c, 20'h0_0005);
    tick(4);
    chk_pin("mode", 2'd1, pmode);
    chk_pin("low_power", 2'd1, {1'b0, lp_cfg});
    rd(5'h00, 8'h48, 0);
    sleep <= 1'b1;
    tick(8);
    chk_pin("mode", 2'd2, pmode);
    chk_pin("active", 2'd1, {1'b0, active});
    sleep <= 1'b0;
    tick(4);
    wr(5'h0c, 20'h0_0009);
    fail <= 1'b1;
    tick(8);
    chk_pin("active", 2'd0, {1'b0, active});
    fail <= 1'b0;
    wr(5'h0c, 20'h0_0000);
    wr(5'h14, 20'h0_0001);
    wr(5'h08, 20'h0_00ff);
    wr(5'h04, 20'h0_00fe);
    wr(5'h00, 20'h0_0009);
    for (i = 0; i < 60 && irq !== 1'b1; i++) tick(1);
    chk_pin("irq", 2'd1, {1'b0, irq});
    wr(5'h00, 20'h0_0008);
    rd(5'h08, 8'h00, 0);
    wr(5'h08, 20'h0_0080);
    rd(5'h08, 8'h80, 0);
    wr(5'h14, 20'h0_0000);
    tick(3);
    chk_pin("irq", 2'd0, {1'b0, irq});
    rd(5'h10, 8'h01, 0);
    wr(5'h10, 20'h0_0000);
    rd(5'h10, 8'h00, 0);
    wr(5'h08, 20'h0_00ff);
    wr(5'h04, 20'h0_00ff);
    tick(100);
    rd(5'h04, 8'hff, 0);
    rd(5'h10, 8'h00, 0);
    for (i = 0; i < 4; i++) begin
        wr(5'h08, 20'h0_0000);
        wr(5'h04, 20'h0_0000);
        wr(5'h00, 20'({i[1:0], 4'h9}));
        tick(256);
        wr(5'h00, 20'h0_0008);
        rd(5'h04, 8'(64 >> i), 2);
    end
    adc_en <= 1'b1;
    for (i = 0; i < 2; i++) begin
        wr(5'h08, 20'h0_0000);
        wr(5'h04, 20'h0_0000);
        wr(i ? 5'h1c : 5'h18, 20'hb_0006);
        wr(5'h00, 20'h0_0009);
        tick(300);
        wr(5'h00, 20'h0_0008);
        rd(5'h04, 8'h03, 3);
        rd(5'h10, 8'h00, 0);
        wr(i ? 5'h1c : 5'h18, 20'h0_0000);
    end
    chk_pin("adc_seen", 2'd1, {1'b0, adc_cnt > 0});
    v = 16'($random(seed));
    wr(5'h00, 20'h0_0088);
    wr(5'h08, 20'(v[15:8]));
    wr(5'h04, 20'(v[7:0]));
    rd(5'h04, v[7:0], 0);
    rd(5'h08, v[15:8], 0);
    wr(5'h00, 20'h0_0008);
    for (i = 0; i < 2; i++) begin
        wr(5'h08, 20'h0_0000);
        wr(5'h04, 20'h0_0000);
        wr(5'h00, 20'({1'b1, i[0], 2'b11}));
        tick(1700);
        wr(5'h00, 20'h0_0008);
        rd(5'h04, 8'h64, 2);
    end
    tick(2);
    close_out();
end
endmodule // lp_osc_timer_counter_tb_top
`default_nettype wire
